// ---- rtl/oser_pkg.sv ----
// package with constants for the otg status and event register block
// Notes on behaviour
// (R1) status bit 9: SE0 held over 2 ms
// (R2) status bit 5: remote pull-up attached
// (R3) wait 50 us after local pull-up off
// (R4) B role: bit 4 shows VBUS above b-valid
// (R5) A role: bit 3 shows VBUS above a-session
// (R6) B role: bit 2 shows VBUS below b-end
// (R7) A role: bit 1 shows VBUS above a-vbus
// (R8) status bit 0 mirrors plug sense pin
// (R9) status 16 bits, reserved 15-10, 8-6
// (R10) event word read 68h, written E8h
// (R11) eleven event flags bits 10-0, reset zero
// (R12) writing one clears a flag, zero ignored
// (R13) change flags set on status bit toggle
// (R14) long-SE0 event set after 2 ms SE0
// (R15) suspend event set after 3 ms idle
// (R16) status writes ignored, reserved read zero
package oser_pkg;
	// clock rate in hertz
	localparam int unsigned CLK_HZ         = 10_000_000;
	// times as printed
	localparam int unsigned SE0_LONG_MS    = 2;
	localparam int unsigned IDLE_SUSP_MS   = 3;
	localparam int unsigned ATTACH_WAIT_US = 50;
	// cycle counts derived from times
	localparam int unsigned SE0_LONG_CYC   = SE0_LONG_MS * (CLK_HZ / 1000);
	localparam int unsigned IDLE_SUSP_CYC  = IDLE_SUSP_MS * (CLK_HZ / 1000);
	localparam int unsigned ATTACH_WAIT_CYC = ATTACH_WAIT_US * (CLK_HZ / 1_000_000);
	// command codes
	localparam logic [7:0]  CMD_EVT_RD     = 8'h68;
	localparam logic [7:0]  CMD_EVT_WR     = 8'he8;
	// status bit positions
	localparam int unsigned ST_LONG_SE0    = 9;
	localparam int unsigned ST_ATTACH      = 5;
	localparam int unsigned ST_B_VALID     = 4;
	localparam int unsigned ST_A_VALID     = 3;
	localparam int unsigned ST_B_END       = 2;
	localparam int unsigned ST_A_VBUS      = 1;
	localparam int unsigned ST_PLUG        = 0;
	// event bit positions
	localparam int unsigned EV_TIMER       = 10;
	localparam int unsigned EV_LONG_SE0    = 9;
	localparam int unsigned EV_SRP         = 8;
	localparam int unsigned EV_RESUME      = 7;
	localparam int unsigned EV_SUSPEND     = 6;
	localparam int unsigned EV_CHG_TOP     = 5;
	// masks of implemented bits
	localparam logic [15:0] STATUS_MASK    = 16'h023f;
	localparam logic [15:0] EVENT_MASK     = 16'h07ff;
	localparam logic [15:0] EVENT_RESET    = 16'h0000;
endpackage

// ---- rtl/oser_regs.sv ----
// otg status word on its own output and sticky event word on its own output and behind the command port
`timescale 1ns/100ps
module oser_regs #(
	parameter int unsigned SE0_CYC    = oser_pkg::SE0_LONG_CYC,
	parameter int unsigned IDLE_CYC   = oser_pkg::IDLE_SUSP_CYC,
	parameter int unsigned ATTACH_CYC = oser_pkg::ATTACH_WAIT_CYC
) (
	input  wire logic        clk,
	input  wire logic        reset,
	// command port
	input  wire logic        cmd_valid,       // one-cycle command strobe
	input  wire logic [7:0]  cmd_code,        // command code
	input  wire logic [15:0] wr_data,         // data for write commands
	output logic [15:0]      rd_data,         // data for read commands
	output logic             rd_valid,        // read data ready
	// line and comparator inputs
	input  wire logic        se0_line,        // bus in single-ended zero
	input  wire logic        bus_idle,        // bus idle (J state)
	input  wire logic        jk_resume,       // J to K change seen
	input  wire logic        local_pullup_on, // local pull-up on positive line
	input  wire logic        remote_pullup,   // far pull-up sensed
	input  wire logic        vbus_b_valid,    // above b_valid_threshold
	input  wire logic        vbus_a_session,  // above a_session_threshold
	input  wire logic        vbus_b_end,      // below b_end_threshold
	input  wire logic        vbus_a_good,     // above a_vbus_threshold
	input  wire logic        plug_sense_pin,  // plug sense level
	input  wire logic        timer_expired,   // otg timer pulse
	input  wire logic        srp_seen,        // session request pulse
	// state out
	output logic [15:0]      otg_line_status, // status word
	output logic [15:0]      otg_event_flags  // event word
);
	initial begin
		// the attach timer counts one less than the settle time, so two is the floor
		if (SE0_CYC < 1 || IDLE_CYC < 1 || ATTACH_CYC < 2) $error("counts too small");
	end

	// whole state in one struct
	typedef struct packed {
		logic [15:0] status;    // registered status word
		logic [15:0] events;    // sticky event flags
		logic        susp;      // port in suspend
		logic        attach_en; // remote attach detection enabled
		logic [15:0] rd;        // read data
		logic        rdv;       // read valid
	} oser_regs_s;

	oser_regs_s  st_q;
	oser_regs_s  st_d;
	logic        se0_long;    // se0 over 2 ms
	logic        idle_long;   // idle over 3 ms
	logic        pullup_off_long; // local pull-up off long enough
	logic [15:0] status_now;  // status from inputs
	logic [15:0] set_v;       // events firing this cycle
	logic [15:0] clr_v;       // events cleared this cycle

	// se0 duration
	oser_timer #(.LIMIT(SE0_CYC)) u_se0 (
		.clk   (clk),
		.reset (reset),
		.level (se0_line),
		.over  (se0_long)
	);

	// idle duration for suspend
	oser_timer #(.LIMIT(IDLE_CYC)) u_idle (
		.clk   (clk),
		.reset (reset),
		.level (bus_idle),
		.over  (idle_long)
	);

	// settle time after local pull-up switched off
	oser_timer #(.LIMIT(ATTACH_CYC - 1)) u_attach (
		.clk   (clk),
		.reset (reset),
		.level (!local_pullup_on),
		.over  (pullup_off_long)
	);

	// status word assembly
	always_comb begin
		status_now = '0; // reserved bits zero, see (R9) see (R16)
		status_now[oser_pkg::ST_LONG_SE0] = se0_long; // see (R1)
		// gate at once on the local pull-up, the enable flop lags one cycle
		status_now[oser_pkg::ST_ATTACH]   = st_q.attach_en & !local_pullup_on
			& remote_pullup; // see (R2) see (R3)
		status_now[oser_pkg::ST_B_VALID]  = plug_sense_pin & vbus_b_valid; // see (R4)
		status_now[oser_pkg::ST_A_VALID]  = !plug_sense_pin & vbus_a_session; // see (R5)
		status_now[oser_pkg::ST_B_END]    = plug_sense_pin & vbus_b_end; // see (R6)
		status_now[oser_pkg::ST_A_VBUS]   = !plug_sense_pin & vbus_a_good; // see (R7)
		status_now[oser_pkg::ST_PLUG]     = plug_sense_pin; // see (R8)
	end

	// next state: events, clears, reads
	always_comb begin
		st_d = st_q;
		st_d.attach_en = local_pullup_on ? 1'b0 : pullup_off_long; // see (R3)
		st_d.status = status_now & oser_pkg::STATUS_MASK;
		st_d.susp = idle_long;
		set_v = '0;
		set_v[oser_pkg::EV_TIMER]    = timer_expired;
		set_v[oser_pkg::EV_LONG_SE0] = se0_long & !st_q.status[oser_pkg::ST_LONG_SE0]; // see (R14)
		set_v[oser_pkg::EV_SRP]      = srp_seen;
		set_v[oser_pkg::EV_RESUME]   = st_q.susp & jk_resume;
		set_v[oser_pkg::EV_SUSPEND]  = idle_long & !st_q.susp; // see (R15)
		set_v[oser_pkg::EV_CHG_TOP:0] = st_d.status[5:0] ^ st_q.status[5:0]; // see (R13)
		clr_v = '0;
		if (cmd_valid && cmd_code == oser_pkg::CMD_EVT_WR) begin // see (R10)
			clr_v = wr_data; // see (R12)
		end
		// set wins over clear
		st_d.events = ((st_q.events & ~clr_v) | set_v) & oser_pkg::EVENT_MASK; // see (R11)
		st_d.rdv = cmd_valid && cmd_code == oser_pkg::CMD_EVT_RD; // see (R10)
		if (st_d.rdv) begin
			st_d.rd = st_q.events;
		end
	end

	// registered state
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= '0; // see (R11)
		end else begin
			st_q <= st_d;
		end
	end

	assign otg_line_status = st_q.status;
	assign otg_event_flags = st_q.events;
	assign rd_data = st_q.rd;
	assign rd_valid = st_q.rdv;

	a_event_clear: assert property (@(posedge clk) disable iff (reset) // see (R12)
		cmd_valid && cmd_code == oser_pkg::CMD_EVT_WR && wr_data[oser_pkg::EV_SRP] && !srp_seen
		|=> !otg_event_flags[oser_pkg::EV_SRP]) else $error("write one did not clear");
	a_event_sticky: assert property (@(posedge clk) disable iff (reset) // see (R12)
		otg_event_flags[oser_pkg::EV_TIMER] && !(cmd_valid && cmd_code == oser_pkg::CMD_EVT_WR)
		|=> otg_event_flags[oser_pkg::EV_TIMER]) else $error("flag dropped without clear");
	a_change_flag: assert property (@(posedge clk) disable iff (reset) // see (R13)
		$changed(otg_line_status[oser_pkg::ST_PLUG]) |-> otg_event_flags[0])
		else $error("change flag missed");
	a_reserved_zero: assert property (@(posedge clk) disable iff (reset) // see (R9)
		(otg_line_status & ~oser_pkg::STATUS_MASK) == '0 && otg_event_flags[15:11] == '0)
		else $error("reserved bit set");
	a_plug_mirror: assert property (@(posedge clk) disable iff (reset) // see (R8)
		##1 otg_line_status[oser_pkg::ST_PLUG] == $past(plug_sense_pin))
		else $error("plug bit wrong");
	a_a_role_only: assert property (@(posedge clk) disable iff (reset) // see (R5)
		otg_line_status[oser_pkg::ST_PLUG] |-> !otg_line_status[oser_pkg::ST_A_VALID]
		&& !otg_line_status[oser_pkg::ST_A_VBUS]) else $error("a flags in b role");
	a_b_role_only: assert property (@(posedge clk) disable iff (reset) // see (R4)
		!otg_line_status[oser_pkg::ST_PLUG] |-> !otg_line_status[oser_pkg::ST_B_VALID]
		&& !otg_line_status[oser_pkg::ST_B_END]) else $error("b flags in a role");
	a_se0_event: assert property (@(posedge clk) disable iff (reset) // see (R14)
		$rose(otg_line_status[oser_pkg::ST_LONG_SE0]) |-> otg_event_flags[oser_pkg::EV_LONG_SE0])
		else $error("long se0 event missed");
	a_read_data: assert property (@(posedge clk) disable iff (reset) // see (R10)
		cmd_valid && cmd_code == oser_pkg::CMD_EVT_RD |=> rd_valid && rd_data == $past(otg_event_flags))
		else $error("read data wrong");
	a_attach_gate: assert property (@(posedge clk) disable iff (reset) // see (R3)
		local_pullup_on |=> !otg_line_status[oser_pkg::ST_ATTACH] [*2])
		else $error("attach seen during hold-off");

	// status bits follow their gated inputs one cycle later
	a_long_se0_bit: assert property (@(posedge clk) disable iff (reset) // see (R1)
		##1 otg_line_status[oser_pkg::ST_LONG_SE0] == $past(se0_long))
		else $error("long se0 bit wrong");
	a_attach_level: assert property (@(posedge clk) disable iff (reset) // see (R2)
		otg_line_status[oser_pkg::ST_ATTACH] |-> $past(remote_pullup))
		else $error("attach without far pull-up");
	a_b_valid_level: assert property (@(posedge clk) disable iff (reset) // see (R4)
		##1 otg_line_status[oser_pkg::ST_B_VALID] == $past(plug_sense_pin & vbus_b_valid))
		else $error("b valid bit wrong");
	a_a_valid_level: assert property (@(posedge clk) disable iff (reset) // see (R5)
		##1 otg_line_status[oser_pkg::ST_A_VALID] == $past(!plug_sense_pin & vbus_a_session))
		else $error("a session bit wrong");
	a_b_end_level: assert property (@(posedge clk) disable iff (reset) // see (R6)
		##1 otg_line_status[oser_pkg::ST_B_END] == $past(plug_sense_pin & vbus_b_end))
		else $error("b end bit wrong");
	a_a_vbus_level: assert property (@(posedge clk) disable iff (reset) // see (R7)
		##1 otg_line_status[oser_pkg::ST_A_VBUS] == $past(!plug_sense_pin & vbus_a_good))
		else $error("a vbus bit wrong");

	// event flags latch their triggers on the next edge
	a_suspend_event: assert property (@(posedge clk) disable iff (reset) // see (R15)
		$rose(idle_long) |=> otg_event_flags[oser_pkg::EV_SUSPEND])
		else $error("suspend event missed");
	a_resume_event: assert property (@(posedge clk) disable iff (reset) // see (R11)
		st_q.susp && jk_resume |=> otg_event_flags[oser_pkg::EV_RESUME])
		else $error("resume event missed");
	a_timer_event: assert property (@(posedge clk) disable iff (reset) // see (R11)
		timer_expired |=> otg_event_flags[oser_pkg::EV_TIMER])
		else $error("timer event missed");
	a_srp_event: assert property (@(posedge clk) disable iff (reset) // see (R11)
		srp_seen |=> otg_event_flags[oser_pkg::EV_SRP])
		else $error("session request event missed");
endmodule

// ---- rtl/oser_timer.sv ----
// saturating duration counter: flags a level held over a cycle count
`timescale 1ns/100ps
module oser_timer #(
	parameter int unsigned LIMIT = 20000
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic level,  // condition being timed
	output logic      over    // level held longer than limit
);
	localparam int unsigned W = $clog2(LIMIT + 2);
	localparam logic [W-1:0] TOP = W'(LIMIT + 1);

	initial begin
		if (LIMIT < 1) $error("limit must be positive");
	end

	// whole state in one struct
	typedef struct packed {
		logic [W-1:0] cnt;  // cycles level has held
	} oser_tmr_s;

	oser_tmr_s st_q;
	oser_tmr_s st_d;

	// count while level holds, saturate above limit
	always_comb begin
		st_d = st_q;
		if (!level) begin
			st_d.cnt = '0;
		end else if (st_q.cnt != TOP) begin
			st_d.cnt = st_q.cnt + W'(1);
		end
	end

	// registered state
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign over = (st_q.cnt == TOP);
endmodule

// ---- verification/oser_far.sv ----
// far-side usb party model: line states, vbus comparators, plug and pull-up
`timescale 1ns/100ps
module oser_far (
	input  wire logic       clk,
	input  wire logic [1:0] bus_st,         // 0 j idle, 1 se0, 2 k
	input  wire logic [1:0] vlev,           // vbus step, 0 lowest
	input  wire logic       pu_in,          // far pull-up fitted
	input  wire logic       plug_in,        // plug sense level
	input  wire logic       srp_in,         // session request pulse
	output logic            se0_line,
	output logic            bus_idle,
	output logic            jk_resume,
	output logic            remote_pullup,
	output logic            vbus_b_valid,
	output logic            vbus_a_session,
	output logic            vbus_b_end,
	output logic            vbus_a_good,
	output logic            plug_sense_pin,
	output logic            srp_seen
);
	logic [1:0] last_q;                     // bus state one cycle ago
	// remember the line state to spot j to k
	always_ff @(posedge clk) begin
		last_q <= bus_st;
	end
	// comparators: end below step 1, valid from 2, vbus good at 3
	assign se0_line       = (bus_st == 2'h1);
	assign bus_idle       = (bus_st == 2'h0);
	assign jk_resume      = (bus_st == 2'h2) && (last_q == 2'h0);
	assign remote_pullup  = pu_in;
	assign vbus_b_end     = (vlev == 2'h0);
	assign vbus_b_valid   = (vlev >= 2'h2);
	assign vbus_a_session = (vlev >= 2'h2);
	assign vbus_a_good    = (vlev == 2'h3);
	assign plug_sense_pin = plug_in;
	assign srp_seen       = srp_in;
endmodule

// ---- verification/oser_regs_tb.sv ----
// self-checking bench for the otg status and event registers
`timescale 1ns/100ps
module oser_regs_tb;
	logic        clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, lpu = 1'b0, tmr = 1'b0;
	logic [7:0]  cmd_code = 8'h00;
	logic [15:0] wr_data = 16'h0000;
	logic [1:0]  bus = 2'h2, v = 2'h0;
	logic        pu = 1'b0, plug = 1'b0, srp = 1'b0;
	wire         se0, idl, jk, rp, bv, as, be, ag, ps, sr, rdv;
	wire [15:0]  rdd, st, ev;
	int          n_errors = 0, comparisons = 0;
	time         cmd_end_t = 0;              // step in which the last strobe dropped
	// clock 100 ns
	always #50 clk = ~clk;
	oser_far far (.clk(clk), .bus_st(bus), .vlev(v), .pu_in(pu), .plug_in(plug),
		.srp_in(srp), .se0_line(se0), .bus_idle(idl), .jk_resume(jk), .remote_pullup(rp),
		.vbus_b_valid(bv), .vbus_a_session(as), .vbus_b_end(be), .vbus_a_good(ag),
		.plug_sense_pin(ps), .srp_seen(sr));
	oser_regs #(.SE0_CYC(8), .IDLE_CYC(12), .ATTACH_CYC(4)) dut (.clk(clk), .reset(reset),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .wr_data(wr_data), .rd_data(rdd),
		.rd_valid(rdv), .se0_line(se0), .bus_idle(idl), .jk_resume(jk),
		.local_pullup_on(lpu), .remote_pullup(rp), .vbus_b_valid(bv),
		.vbus_a_session(as), .vbus_b_end(be), .vbus_a_good(ag), .plug_sense_pin(ps),
		.timer_expired(tmr), .srp_seen(sr), .otg_line_status(st), .otg_event_flags(ev));
	// expected status word from plug, vbus step, attach and long se0
	function automatic logic [15:0] es(input logic p, input logic [1:0] l, input logic a,
		input logic s);
		es = {6'h00, s, 3'h0, a, p & (l >= 2'h2), !p & (l >= 2'h2), p & (l == 2'h0),
			!p & (l == 2'h3), p};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// one command strobe, held through its taking edge
	task automatic cmd(input logic [7:0] c, input logic [15:0] d);
		if (cmd_end_t == $time) step(1);
		cmd_valid = 1'b1;
		cmd_code = c;
		wr_data = d;
		step(1);
		cmd_valid = 1'b0;
		cmd_end_t = $time;
	endtask
	// read event word and compare, bounded wait on rd_valid
	task automatic rd(input logic [15:0] exp);
		int i;
		cmd(8'h68, 16'h0000);
		for (i = 0; i < 4 && rdv !== 1'b1; i++) step(1);
		if (rdv !== 1'b1) begin
			n_errors++;
			$display("ERROR at %0t got %h expected %h", $time, rdv, 1'b1);
		end
		chk(rdd, exp);
		step(1);
	endtask
	task automatic test_done;
		if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		step(5);
		reset = 1'b0;
		step(2);
		chk(st, 16'h0000);
		rd(16'h0000);
		plug = 1'b1;
		v = 2'h3;
		step(2);
		chk(st, es(1, 3, 0, 0));
		rd(16'h0011);
		cmd(8'he8, 16'h0000);
		rd(16'h0011);
		cmd(8'he8, 16'h0001);
		rd(16'h0010);
		cmd(8'he8, 16'hffff);
		plug = 1'b0;
		step(2);
		chk(st, es(0, 3, 0, 0));
		rd(16'h001b);
		cmd(8'h55, 16'hffff);
		chk(st, es(0, 3, 0, 0));
		rd(16'h001b);
		cmd(8'he8, 16'hffff);
		bus = 2'h1;
		step(7);
		chk(st, es(0, 3, 0, 0));
		step(4);
		chk(st, es(0, 3, 0, 1));
		rd(16'h0200);
		cmd(8'he8, 16'hffff);
		bus = 2'h0;
		step(16);
		rd(16'h0040);
		bus = 2'h2;
		step(2);
		rd(16'h00c0);
		cmd(8'he8, 16'hffff);
		lpu = 1'b1;
		pu = 1'b1;
		step(3);
		lpu = 1'b0;
		step(1);
		chk(st, es(0, 3, 0, 0));
		step(8);
		chk(st, es(0, 3, 1, 0));
		tmr = 1'b1;
		srp = 1'b1;
		step(1);
		tmr = 1'b0;
		srp = 1'b0;
		chk(ev, 16'h0520);
		rd(16'h0520);
		cmd(8'he8, 16'hffff);
		chk(ev, 16'h0000);
		rd(16'h0000);
		test_done();
	end
endmodule
